// ### pkg/dbs_pkg.sv
// Functional notes
// - fixed two-beat burst, one address per burst
// - data width strap selects x36 or x18
// - commands only on alternating primary rising edges
// - rising edge samples address, controls, first beat
// - complementary edge samples second beat, enables
// - low byte enable per beat writes lane
// - first read beat one and half cycles later
// - second read beat on third true edge
// - tied output clocks mean input clocks time data
// - echo clocks travel aligned with read data
// - operations start on primary edge, then self-timed
// - loop disable gives one cycle less latency
// - echo clocks keep running while outputs float
package dbs_pkg;

    // -----------------------------------------------------------------
    // organisation
    // -----------------------------------------------------------------
    localparam int DATA_W     = 36;
    localparam int LANE_W     = 9;
    localparam int LANES      = 4;
    localparam int LANES_X18  = 2;
    localparam int ADDR_W     = 21;
    localparam int ADDR_X36_W = 20;
    localparam int ENTRY_W    = 18;
    localparam int IDX_W      = 22;
    localparam int MEM_DEPTH  = 4194304;
    localparam int BURST_LEN  = 2;

    // lane masks for the two organisations
    localparam logic [DATA_W-1:0] MASK_X36 = 36'hf_ffff_ffff;
    localparam logic [DATA_W-1:0] MASK_X18 = 36'h0_0003_ffff;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int SYS_CLK_HZ      = 20000000;
    localparam int DLL_OFF_MAX_MHZ = 167;
    // link edges after reset release before the width strap is caught
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // command decoded on a primary rising edge
    typedef enum logic [1:0] {
        DBS_NOP,
        DBS_READ,
        DBS_WRITE,
        DBS_SKIP
    } dbs_cmd_t;

endpackage

// ### src/dbs_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop level synchroniser; first stage feeds only the second
module dbs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    // -----------------------------------------------------------------
    // capture stages
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ### src/dbs_port.sv
`timescale 1ns/100ps
`default_nettype none
module dbs_port
    import dbs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              k_clk,
    input  wire logic [ADDR_W-1:0] burst_address,
    input  wire logic              load_strobe_n,
    input  wire logic              read_not_write,
    input  wire logic [LANES-1:0]  byte_enable_n,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_oe,
    input  wire logic              out_clk,
    input  wire logic              out_clk_n,
    input  wire logic              dll_bypass_n,
    input  wire logic              width_x18,
    output logic                   echo_clock_true,
    output logic                   echo_clock_comp,
    output logic                   mode_is_x18,
    input  wire logic              error_clear,
    output logic                   spacing_error
);

    // -----------------------------------------------------------------
    // pin synchronisers on the link clock
    // -----------------------------------------------------------------
    logic [3:0] pin_sync;
    logic       dll_on;
    logic       out_clk_tied;

    dbs_sync #(
        .W (4)
    ) u_pin_sync (
        .clk     (k_clk),
        .reset_n (reset_n),
        .d       ({dll_bypass_n, width_x18, out_clk, out_clk_n}),
        .q       (pin_sync)
    );

    // static straps: loop disable level and output clock tie-off
    assign dll_on       = pin_sync[3];
    assign out_clk_tied = pin_sync[1] & pin_sync[0];

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    // 72 Mb kept as 18-bit entries; x36 uses two entries per beat
    logic [ENTRY_W-1:0] mem [MEM_DEPTH];

    function automatic logic [IDX_W-1:0] entry_idx(
        input logic              x18,
        input logic [ADDR_W-1:0] a,
        input logic              beat,
        input logic              hi
    );
        entry_idx = x18 ? {a, beat} : {a[ADDR_X36_W-1:0], beat, hi};
    endfunction

    // -----------------------------------------------------------------
    // rising-edge state
    // -----------------------------------------------------------------
    logic [1:0]        strap_cnt;
    logic              mode_x18;
    logic              cmd_gap;
    logic              wr_s1;
    logic              wr_s2;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0]  wr_be0;
    logic [DATA_W-1:0] wr_d0;
    logic              rd_s1;
    logic              rd_s2;
    logic [DATA_W-1:0] rd_d0;
    logic [DATA_W-1:0] rd_d1;
    logic [DATA_W-1:0] q_pos;
    logic [DATA_W-1:0] oe_pos;
    logic              err_tgl;
    logic              echo_p;

    logic [1:0]        next_strap_cnt;
    logic              next_mode_x18;
    logic              next_cmd_gap;
    logic              next_wr_s1;
    logic              next_wr_s2;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [LANES-1:0]  next_wr_be0;
    logic [DATA_W-1:0] next_wr_d0;
    logic              next_rd_s1;
    logic              next_rd_s2;
    logic [DATA_W-1:0] next_rd_d0;
    logic [DATA_W-1:0] next_rd_d1;
    logic [DATA_W-1:0] next_q_pos;
    logic [DATA_W-1:0] next_oe_pos;
    logic              next_err_tgl;
    logic              next_echo_p;

    // -----------------------------------------------------------------
    // falling-edge state (complementary input clock)
    // -----------------------------------------------------------------
    logic [LANES-1:0]  wr_be1;
    logic [DATA_W-1:0] wr_d1;
    logic [DATA_W-1:0] q_neg;
    logic [DATA_W-1:0] oe_neg;
    logic              echo_n;

    logic [LANES-1:0]  next_wr_be1;
    logic [DATA_W-1:0] next_wr_d1;
    logic [DATA_W-1:0] next_q_neg;
    logic [DATA_W-1:0] next_oe_neg;
    logic              next_echo_n;

    // command and address decode
    dbs_cmd_t          cmd;
    logic [ADDR_W-1:0] eff_addr;
    logic [DATA_W-1:0] live_mask;
    logic [DATA_W-1:0] fetch0;
    logic [DATA_W-1:0] fetch1;

    assign live_mask   = mode_x18 ? MASK_X18 : MASK_X36;
    assign mode_is_x18 = mode_x18;

    // -----------------------------------------------------------------
    // decode on the primary rising edge
    // -----------------------------------------------------------------
    // commands wait until the strap is caught; a command one edge after a
    // taken read or write is refused so a stray strobe cannot split a burst
    always_comb begin
        eff_addr = mode_x18 ? burst_address : {1'b0, burst_address[ADDR_X36_W-1:0]};
        if (load_strobe_n || strap_cnt <= STRAP_SETTLE) begin
            cmd = DBS_NOP;
        end else if (cmd_gap) begin
            cmd = DBS_SKIP;
        end else if (read_not_write) begin
            cmd = DBS_READ;
        end else begin
            cmd = DBS_WRITE;
        end
    end

    // read fetch from the array, merged with a write still in the buffer
    always_comb begin
        fetch0 = '0;
        fetch1 = '0;
        for (int l = 0; l < LANES; l++) begin
            if (!mode_x18 || l < LANES_X18) begin
                fetch0[l*LANE_W +: LANE_W] =
                    mem[entry_idx(mode_x18, eff_addr, 1'b0, l[1])][(l & 1)*LANE_W +: LANE_W];
                fetch1[l*LANE_W +: LANE_W] =
                    mem[entry_idx(mode_x18, eff_addr, 1'b1, l[1])][(l & 1)*LANE_W +: LANE_W];
                if (wr_s2 && wr_addr == eff_addr && !wr_be0[l]) begin
                    fetch0[l*LANE_W +: LANE_W] = wr_d0[l*LANE_W +: LANE_W];
                end
                if (wr_s2 && wr_addr == eff_addr && !wr_be1[l]) begin
                    fetch1[l*LANE_W +: LANE_W] = wr_d1[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // rising-edge next values
    // -----------------------------------------------------------------
    always_comb begin
        next_strap_cnt = strap_cnt;
        next_mode_x18  = mode_x18;
        next_cmd_gap   = 1'b0;
        next_wr_s1     = 1'b0;
        next_wr_s2     = wr_s1;
        next_wr_addr   = wr_addr;
        next_wr_be0    = wr_be0;
        next_wr_d0     = wr_d0;
        next_rd_s1     = 1'b0;
        next_rd_s2     = rd_s1;
        next_rd_d0     = rd_d0;
        next_rd_d1     = rd_d1;
        next_err_tgl   = err_tgl;
        next_echo_p    = ~echo_p; // free running
        // catch the width strap once, after the synchroniser has settled
        if (strap_cnt <= STRAP_SETTLE) begin
            next_strap_cnt = strap_cnt + 2'h1;
        end
        if (strap_cnt == STRAP_SETTLE) begin
            next_mode_x18 = pin_sync[2];
        end
        unique case (cmd)
            DBS_NOP: begin
            end
            DBS_SKIP: begin
                next_err_tgl = ~err_tgl;
            end
            DBS_READ: begin
                next_cmd_gap = 1'b1;
                next_rd_s1   = 1'b1;
                next_rd_d0   = fetch0; // one address, both beats
                next_rd_d1   = fetch1;
            end
            DBS_WRITE: begin
                next_cmd_gap = 1'b1;
                next_wr_s1   = 1'b1;
                next_wr_addr = eff_addr;
            end
        endcase
        // first write beat arrives one cycle after the command
        if (wr_s1) begin
            next_wr_be0 = byte_enable_n;
            next_wr_d0  = dq_in & live_mask;
        end
        // second read beat: two edges after the command, one with loop off
        if (dll_on ? rd_s2 : rd_s1) begin
            next_q_pos  = rd_d1;
            next_oe_pos = live_mask;
        end else begin
            next_q_pos  = q_pos;
            next_oe_pos = '0;
        end
    end

    always_ff @(posedge k_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt <= '0;
            mode_x18  <= 1'b0;
            cmd_gap   <= 1'b0;
            wr_s1     <= 1'b0;
            wr_s2     <= 1'b0;
            wr_addr   <= '0;
            wr_be0    <= '1;
            wr_d0     <= '0;
            rd_s1     <= 1'b0;
            rd_s2     <= 1'b0;
            rd_d0     <= '0;
            rd_d1     <= '0;
            q_pos     <= '0;
            oe_pos    <= '0;
            err_tgl   <= 1'b0;
            echo_p    <= 1'b0;
        end else begin
            strap_cnt <= next_strap_cnt;
            mode_x18  <= next_mode_x18;
            cmd_gap   <= next_cmd_gap;
            wr_s1     <= next_wr_s1;
            wr_s2     <= next_wr_s2;
            wr_addr   <= next_wr_addr;
            wr_be0    <= next_wr_be0;
            wr_d0     <= next_wr_d0;
            rd_s1     <= next_rd_s1;
            rd_s2     <= next_rd_s2;
            rd_d0     <= next_rd_d0;
            rd_d1     <= next_rd_d1;
            q_pos     <= next_q_pos;
            oe_pos    <= next_oe_pos;
            err_tgl   <= next_err_tgl;
            echo_p    <= next_echo_p;
        end
    end

    // late write: commit both beats on the edge after the second beat
    always_ff @(posedge k_clk) begin
        if (wr_s2) begin
            for (int l = 0; l < LANES; l++) begin
                if ((!mode_x18 || l < LANES_X18) && !wr_be0[l]) begin
                    mem[entry_idx(mode_x18, wr_addr, 1'b0, l[1])][(l & 1)*LANE_W +: LANE_W]
                        <= wr_d0[l*LANE_W +: LANE_W];
                end
                if ((!mode_x18 || l < LANES_X18) && !wr_be1[l]) begin
                    mem[entry_idx(mode_x18, wr_addr, 1'b1, l[1])][(l & 1)*LANE_W +: LANE_W]
                        <= wr_d1[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // falling-edge next values
    // -----------------------------------------------------------------
    always_comb begin
        next_wr_be1 = wr_be1;
        next_wr_d1  = wr_d1;
        next_echo_n = echo_p; // trails the rising flop so the phase cannot slip
        if (wr_s2) begin
            next_wr_be1 = byte_enable_n;
            next_wr_d1  = dq_in & live_mask;
        end
        // first read beat half a cycle before the second
        if (dll_on ? rd_s2 : rd_s1) begin
            next_q_neg  = rd_d0;
            next_oe_neg = live_mask;
        end else begin
            next_q_neg  = q_neg;
            next_oe_neg = '0;
        end
    end

    always_ff @(negedge k_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_be1 <= '1;
            wr_d1  <= '0;
            q_neg  <= '0;
            oe_neg <= '0;
            echo_n <= 1'b0;
        end else begin
            wr_be1 <= next_wr_be1;
            wr_d1  <= next_wr_d1;
            q_neg  <= next_q_neg;
            oe_neg <= next_oe_neg;
            echo_n <= next_echo_n;
        end
    end

    // -----------------------------------------------------------------
    // output launch and echo clocks
    // -----------------------------------------------------------------
    // launch edges are the input pair whether or not the output pair is
    // tied high; an untied output pair only shifts board-level skew,
    // which this logic cannot see, so it picks the same edges
    always_comb begin
        echo_clock_true = echo_p ^ echo_n;
        echo_clock_comp = ~(echo_p ^ echo_n);
        if (echo_p ^ echo_n) begin
            dq_out = q_pos;
            dq_oe  = oe_pos;
        end else begin
            dq_out = q_neg;
            dq_oe  = out_clk_tied ? oe_neg : oe_neg & live_mask;
        end
    end

    // -----------------------------------------------------------------
    // system-clock side: refused command reporting
    // -----------------------------------------------------------------
    logic err_sync;
    logic err_seen;
    logic next_err_seen;
    logic next_spacing_error;

    dbs_sync #(
        .W (1)
    ) u_err_sync (
        .clk     (clk_sys),
        .reset_n (reset_n),
        .d       (err_tgl),
        .q       (err_sync)
    );

    // sticky flag; a new event wins over a clear in the same cycle
    always_comb begin
        next_err_seen      = err_sync;
        next_spacing_error = (err_sync ^ err_seen) | (spacing_error & ~error_clear);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            err_seen      <= 1'b0;
            spacing_error <= 1'b0;
        end else begin
            err_seen      <= next_err_seen;
            spacing_error <= next_spacing_error;
        end
    end

endmodule
`default_nettype wire

// ### test/dbs_port_props.sv
`timescale 1ns/100ps
`default_nettype none
// checker bound to the port; watches pins only
module dbs_port_props
    import dbs_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              k_clk,
    input wire logic              load_strobe_n,
    input wire logic              read_not_write,
    input wire logic [DATA_W-1:0] dq_oe,
    input wire logic              dll_bypass_n,
    input wire logic              echo_clock_true,
    input wire logic              echo_clock_comp,
    input wire logic              mode_is_x18,
    input wire logic              error_clear,
    input wire logic              spacing_error
);
    // ------------
    // command tracking
    // ------------
    logic acc_q;
    logic next_acc_q;
    logic ref_tgl;
    logic next_ref_tgl;
    logic cmd_acc;

    // a strobe right after a taken command is refused, so it never counts
    always_comb begin
        cmd_acc      = !load_strobe_n && !acc_q;
        next_acc_q   = cmd_acc;
        next_ref_tgl = ref_tgl ^ (!load_strobe_n && acc_q);
    end

    // toggle form lets the system domain see each refusal
    always_ff @(posedge k_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q   <= 1'b0;
            ref_tgl <= 1'b0;
        end else begin
            acc_q   <= next_acc_q;
            ref_tgl <= next_ref_tgl;
        end
    end

    // ------------
    // properties
    // ------------
    sequence s_beats;
        (dq_oe != '0) ##1 (dq_oe == '0);
    endsequence

    chk_rd_loop_on: assert property (@(posedge k_clk) disable iff (!reset_n)
        cmd_acc && read_not_write && dll_bypass_n |-> ##2 s_beats)
        else $error("read window wrong with loop on");
    chk_rd_loop_off: assert property (@(posedge k_clk) disable iff (!reset_n)
        cmd_acc && read_not_write && !dll_bypass_n |-> ##1 s_beats)
        else $error("read window wrong with loop off");
    chk_oe_whole: assert property (@(posedge k_clk) disable iff (!reset_n)
        dq_oe == '0 || dq_oe == (mode_is_x18 ? MASK_X18 : MASK_X36))
        else $error("partial output enable");
    chk_x18_upper: assert property (@(negedge k_clk) disable iff (!reset_n)
        mode_is_x18 |-> dq_oe[DATA_W-1:18] == '0)
        else $error("upper lanes driven in x18");
    chk_echo_pair: assert property (@(negedge k_clk) disable iff (!reset_n)
        echo_clock_comp == !echo_clock_true)
        else $error("echo pair not complementary");
    chk_echo_rise: assert property (@(posedge k_clk) disable iff (!reset_n)
        !echo_clock_true)
        else $error("echo not low before rising edge");
    chk_echo_fall: assert property (@(negedge k_clk) disable iff (!reset_n)
        $past(reset_n) |-> echo_clock_true)
        else $error("echo not high before falling edge");
    chk_err_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        spacing_error && !error_clear |=> spacing_error)
        else $error("spacing flag dropped");
    chk_err_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        error_clear |=> !spacing_error)
        else $error("spacing flag not cleared");
    chk_err_raise: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $changed(ref_tgl) |-> ##[0:4] spacing_error)
        else $error("refusal not flagged");
endmodule
`default_nettype wire

// ### test/dbs_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
// controller model: one write, then a read two edges later
module dbs_ctrl_model
    import dbs_pkg::*;
(
    input  wire logic              k_clk,
    output logic      [ADDR_W-1:0] burst_address,
    output logic                   load_strobe_n,
    output logic                   read_not_write,
    output logic      [LANES-1:0]  byte_enable_n,
    output logic      [DATA_W-1:0] dq_in,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic [DATA_W-1:0] dq_oe
);
    // idle: no strobe, all lanes off
    initial begin
        burst_address  = '0;
        load_strobe_n  = 1'b1;
        read_not_write = 1'b1;
        byte_enable_n  = 4'hf;
        dq_in          = '0;
    end

    // lo selects the shorter read latency of the bypassed loop
    task automatic xfer(input logic [ADDR_W-1:0] wa, ra, input logic [DATA_W-1:0] d0, d1,
                        input logic [LANES-1:0] e0, e1, input bit lo,
                        output logic [DATA_W-1:0] r0, r1, oe, oe_end);
        @(posedge k_clk);
        load_strobe_n  <= 1'b0;
        read_not_write <= 1'b0;
        burst_address  <= wa;       // one address per burst
        @(posedge k_clk);
        load_strobe_n  <= 1'b1;
        dq_in          <= d0;       // beat 0 one cycle late
        byte_enable_n  <= e0;
        @(posedge k_clk);
        dq_in          <= d1;       // beat 1 for the falling edge
        byte_enable_n  <= e1;
        load_strobe_n  <= 1'b0;     // every other edge
        read_not_write <= 1'b1;
        burst_address  <= ra;
        @(posedge k_clk);
        load_strobe_n  <= 1'b1;
        dq_in          <= ~d1;      // released lines never keep the last beat
        byte_enable_n  <= 4'hf;
        if (!lo) begin
            @(posedge k_clk);
        end
        @(negedge k_clk);
        #1;
        r0 = dq_out;
        oe = dq_oe;
        @(posedge k_clk);
        #1;
        r1 = dq_out;
        @(negedge k_clk);
        #1;
        oe_end = dq_oe;
    endtask

    // a read, then a write on the very next edge
    task automatic bad_cmd(input logic [ADDR_W-1:0] a);
        @(posedge k_clk);
        load_strobe_n  <= 1'b0;
        read_not_write <= 1'b1;
        burst_address  <= a;
        @(posedge k_clk);
        read_not_write <= 1'b0;
        @(posedge k_clk);
        load_strobe_n  <= 1'b1;
        dq_in          <= '0;
        byte_enable_n  <= 4'h0;
        repeat (2) @(posedge k_clk);
        dq_in          <= '1;
        byte_enable_n  <= 4'hf;
        repeat (4) @(posedge k_clk);
    endtask
endmodule
`default_nettype wire

// ### test/dbs_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dbs_port_tb_top
    import dbs_pkg::*;
;
    logic              clk_sys      = 1'b0;
    logic              k_clk        = 1'b0;
    logic              reset_n      = 1'b0;
    logic              out_clk      = 1'b0;
    logic              out_clk_n    = 1'b1;
    logic              dll_bypass_n = 1'b1;
    logic              width_x18    = 1'b0;
    logic              error_clear  = 1'b0;
    logic [ADDR_W-1:0] burst_address;
    logic              load_strobe_n;
    logic              read_not_write;
    logic [LANES-1:0]  byte_enable_n;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
    logic              echo_clock_true;
    logic              echo_clock_comp;
    logic              mode_is_x18;
    logic              spacing_error;
    logic [DATA_W-1:0] mem0 [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] mem1 [logic [ADDR_W-1:0]];
    int                failures     = 0;
    int                num_checks   = 0;

    always #25 clk_sys = ~clk_sys;
    // offset keeps link edges off the system edges
    initial begin
        #1.3;
        forever #3 k_clk = ~k_clk;
    end

    dbs_port dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .k_clk(k_clk), .burst_address(burst_address),
        .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
        .byte_enable_n(byte_enable_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .out_clk(out_clk), .out_clk_n(out_clk_n), .dll_bypass_n(dll_bypass_n),
        .width_x18(width_x18), .echo_clock_true(echo_clock_true),
        .echo_clock_comp(echo_clock_comp), .mode_is_x18(mode_is_x18),
        .error_clear(error_clear), .spacing_error(spacing_error)
    );

    dbs_ctrl_model ctrl_u (
        .k_clk(k_clk), .burst_address(burst_address), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .byte_enable_n(byte_enable_n), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe)
    );

    // ------------
    // helpers
    // ------------
    task automatic check(input bit ok, input string what);
        num_checks++;
        if (!ok) begin
            failures++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic do_reset(input logic x18);
        @(posedge clk_sys);
        reset_n   <= 1'b0;
        width_x18 <= x18;
        mem0.delete();
        mem1.delete();
        idle(2);
        reset_n <= 1'b1;
        idle(4);
        check(mode_is_x18 === x18, "width mode");
    endtask

    // lanes with a low enable take the new byte
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                                input logic [LANES-1:0] e);
        for (int i = 0; i < LANES; i++) begin
            if (!e[i]) begin
                o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
            end
        end
        return o;
    endfunction

    // new addresses must be written in full first, else expectations stay unknown
    task automatic run(input logic [ADDR_W-1:0] wa, ra, input logic [DATA_W-1:0] d0, d1,
                       input logic [LANES-1:0] e0, e1);
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] r0;
        logic [DATA_W-1:0] r1;
        logic [DATA_W-1:0] oe;
        logic [DATA_W-1:0] oe_end;
        m = width_x18 ? MASK_X18 : MASK_X36;
        mem0[wa] = merge(mem0[wa], d0 & m, e0);
        mem1[wa] = merge(mem1[wa], d1 & m, e1);
        ctrl_u.xfer(wa, ra, d0 & m, d1 & m, e0, e1, !dll_bypass_n, r0, r1, oe, oe_end);
        check(((r0 ^ mem0[ra]) & m) === '0, "read beat 0");
        check(((r1 ^ mem1[ra]) & m) === '0, "read beat 1");
        check(oe === m && oe_end === '0, "output enable window");
    endtask

    // ------------
    // scenarios
    // ------------
    task automatic sc_forward();
        run(21'h00_00a5, 21'h00_00a5, 36'h1_2345_6789, 36'he_dcba_9876, 4'h0, 4'h0);
        run(21'h0f_fff0, 21'h00_00a5, 36'h5_5555_5555, 36'ha_aaaa_aaaa, 4'h0, 4'h0);
    endtask

    task automatic sc_lanes();
        run(21'h00_00a5, 21'h00_00a5, 36'h3_0f0f_0f0f, 36'hc_f0f0_f0f0, 4'h5, 4'ha);
        run(21'h00_0100, 21'h00_00a5, 36'h0_0000_0001, 36'h0_0000_0002, 4'h0, 4'h0);
    endtask

    task automatic sc_bypass();
        @(posedge clk_sys);
        dll_bypass_n <= 1'b0;
        idle(4);
        run(21'h00_0200, 21'h00_0200, 36'h7_1111_2222, 36'h8_3333_4444, 4'h0, 4'h0);
        run(21'h00_0300, 21'h00_0200, 36'h0_abcd_ef01, 36'h6_0000_ffff, 4'h9, 4'h0);
        @(posedge clk_sys);
        dll_bypass_n <= 1'b1;
        idle(4);
    endtask

    task automatic sc_tied();
        @(posedge clk_sys);
        out_clk   <= 1'b1;
        out_clk_n <= 1'b1;
        idle(4);
        run(21'h00_0300, 21'h00_0300, 36'h2_4680_1357, 36'h9_7531_0864, 4'h0, 4'h0);
        @(posedge clk_sys);
        out_clk   <= 1'b0;
        out_clk_n <= 1'b1;
    endtask

    task automatic sc_refuse();
        int n;
        ctrl_u.bad_cmd(21'h00_0300);
        n = 0;
        while (spacing_error !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        check(spacing_error === 1'b1, "refused command not flagged");
        if (spacing_error !== 1'b1) begin
            stop_test();
        end
        @(posedge clk_sys);
        error_clear <= 1'b1;
        @(posedge clk_sys);
        error_clear <= 1'b0;
        idle(1);
        check(spacing_error === 1'b0, "flag not cleared");
        run(21'h00_0400, 21'h00_0300, 36'h0_1234_5678, 36'h0_8765_4321, 4'h0, 4'h0);
    endtask

    task automatic sc_x18();
        do_reset(1'b1);
        run(21'h1f_0001, 21'h1f_0001, 36'h0_0002_5a5a, 36'h0_0001_a5a5, 4'h0, 4'h0);
        run(21'h0f_0001, 21'h1f_0001, 36'h0_0003_ffff, 36'h0_0000_0000, 4'h0, 4'h0);
    endtask

    initial begin
        do_reset(1'b0);
        sc_forward();
        sc_lanes();
        sc_bypass();
        sc_tied();
        sc_refuse();
        sc_x18();
        stop_test();
    end

    // cut a hang short
    initial begin
        #400000;
        failures++;
        stop_test();
    end
endmodule

bind dbs_port dbs_port_props chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .k_clk(k_clk), .load_strobe_n(load_strobe_n),
    .read_not_write(read_not_write), .dq_oe(dq_oe), .dll_bypass_n(dll_bypass_n),
    .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
    .mode_is_x18(mode_is_x18), .error_clear(error_clear), .spacing_error(spacing_error)
);
`default_nettype wire
